/* tcs_defines.svh */
// Register map, field positions, reset values and timing figures of the timer front end
// Function
// - Two count bytes form one 16-bit counter; a select bit picks timer or event counting.
// - Timer operation advances once per tick from clock divided by prescale plus one.
// - Compatibility operation prescales outside the generator modes; prescale resets to 5, one count per six clocks.
// - In compatibility operation the rate select bit doubles the division.
// - Fast operation counts every clock unless rate select is set, then divides by prescale plus one.
// - Baud rate and frequency generator modes bypass the prescaler.
// - Fast counter operation samples the pin each clock; a high then low counts once.
// - The incremented count shows in the cycle after the edge was detected.
// - Compatibility counter sampling is paced by the prescaler, six clocks by default.
// - Mode priority: off, frequency generator, baud generator, capture, up/down, auto-reload.
// - Minimum is 0000H, maximum FFFFH, bottom is the reload/capture pair; the counter wraps to 0000H instead.
// - Overflow sets the overflow flag unless a serial clock select is set; software clears it.
// - Run bit set starts counting; clear stops and holds the count.
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH
`define TCS_CTRL_OFFS 8'h00
`define TCS_MODE_OFFS 8'h04
`define TCS_COUNT_OFFS 8'h08
`define TCS_RELOAD_OFFS 8'h0C
`define TCS_STATUS_OFFS 8'h10
// Primary control register fields
`define TCS_CT_OVF 7
`define TCS_CT_RXCLK 5
`define TCS_CT_TXCLK 4
`define TCS_CT_RUN 2
`define TCS_CT_CNTSEL 1
`define TCS_CT_CAPSEL 0
// Mode control register fields
`define TCS_MD_TOGGLE 1
`define TCS_MD_DOWN 0
`define TCS_MD_RATE 8
`define TCS_MD_FAST 9
`define TCS_MD_PSC_LSB 12
`define TCS_PSC_RESET 4'h5
`define TCS_COUNT_MIN 16'h0000
`define TCS_COUNT_MAX 16'hFFFF
`endif

/* tcs_pkg.sv */
// Types shared by the timer front end
`default_nettype none
package tcs_pkg;
    typedef enum logic [2:0] {
        TCS_OFF = 3'b000,
        TCS_RELOAD = 3'b001,
        TCS_UPDOWN = 3'b010,
        TCS_CAPTURE = 3'b011,
        TCS_BAUD = 3'b100,
        TCS_FREQ = 3'b101
    } tcs_mode_t;
endpackage
`default_nettype wire

/* tcs_prescaler.sv */
// Prescale divider producing the count tick enable
`default_nettype none
`include "tcs_defines.svh"
module tcs_prescaler
    import tcs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] psc,
    input wire logic bypass,
    input wire logic double,
    output logic tick
);
    logic [4:0] cnt_reg;
    logic [3:0] psc_last_reg;
    logic [4:0] top;
    logic changed;
    // Division is (psc+1), or 2*(psc+1) when doubled
    assign top = double ? ({1'b0, psc} << 1) + 5'd1 : {1'b0, psc};
    assign changed = psc != psc_last_reg;
    always_ff @(posedge mclk)
    begin
        if (rst)
            psc_last_reg <= `TCS_PSC_RESET;
        else
            psc_last_reg <= psc;
    end
    always_ff @(posedge mclk)
    begin
        if (rst || changed)
            cnt_reg <= 5'd0;
        else if (cnt_reg >= top)
            cnt_reg <= 5'd0;
        else
            cnt_reg <= cnt_reg + 5'd1;
    end
    // Gated off during a psc change so the first tick after a new psc is never early
    assign tick = bypass | (!changed && cnt_reg >= top);
endmodule
`default_nettype wire

/* tcs_sync.sv */
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module tcs_sync
    import tcs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end
        else
        begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            level <= 1'b1;
        else if (s2_reg == s3_reg)
            level <= s3_reg;
    end
endmodule
`default_nettype wire

/* tcs_timer2.sv */
// Timer front end: count source, prescaler rules, mode decode and AXI4-Lite registers
`default_nettype none
`include "tcs_defines.svh"
module tcs_timer2
    import tcs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic event_count_pin,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] mode,
    output logic tick
);
    logic [7:0] primary_control_register_reg;
    logic [15:0] mode_control_register_reg;
    logic [7:0] count_high_byte_reg;
    logic [7:0] count_low_byte_reg;
    logic [7:0] reload_capture_high_reg;
    logic [7:0] reload_capture_low_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_full_reg;
    logic w_full_reg;
    logic pin_level;
    logic pin_prev_reg;
    logic presc_tick;
    logic presc_bypass;
    logic presc_double;
    logic fast_mode;
    logic rate_select_bit;
    logic [3:0] shared_prescale_value;
    logic run_control_bit;
    logic timer_or_counter_select;
    logic serial_clk_sel;
    logic count_en;
    logic sample;
    logic overflow;
    logic do_write;
    logic wr_ctrl;
    logic wr_count;
    logic [15:0] count_next;
    tcs_mode_t mode_next;

    assign run_control_bit = primary_control_register_reg[`TCS_CT_RUN];
    assign timer_or_counter_select = primary_control_register_reg[`TCS_CT_CNTSEL];
    assign serial_clk_sel = primary_control_register_reg[`TCS_CT_RXCLK]
        | primary_control_register_reg[`TCS_CT_TXCLK];
    assign rate_select_bit = mode_control_register_reg[`TCS_MD_RATE];
    assign fast_mode = mode_control_register_reg[`TCS_MD_FAST];
    assign shared_prescale_value = mode_control_register_reg[`TCS_MD_PSC_LSB +: 4];

    // Mode decode in priority order
    always_comb
    begin
        if (!run_control_bit)
            mode_next = TCS_OFF;
        else if (mode_control_register_reg[`TCS_MD_TOGGLE])
            mode_next = TCS_FREQ;
        else if (serial_clk_sel)
            mode_next = TCS_BAUD;
        else if (primary_control_register_reg[`TCS_CT_CAPSEL])
            mode_next = TCS_CAPTURE;
        else if (mode_control_register_reg[`TCS_MD_DOWN])
            mode_next = TCS_UPDOWN;
        else
            mode_next = TCS_RELOAD;
    end
    assign mode = mode_next;

    assign presc_bypass = mode_next == TCS_BAUD || mode_next == TCS_FREQ
        || (fast_mode && !rate_select_bit);
    assign presc_double = !fast_mode && rate_select_bit;

    tcs_prescaler u_presc (
        .mclk(mclk),
        .rst(rst),
        .psc(shared_prescale_value),
        .bypass(presc_bypass),
        .double(presc_double),
        .tick(presc_tick)
    );

    tcs_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .pin(event_count_pin),
        .level(pin_level)
    );

    // Pin sampling is every clock in fast mode, at the prescaler pace otherwise
    assign sample = fast_mode ? 1'b1 : presc_tick;
    always_ff @(posedge mclk)
    begin
        if (rst)
            pin_prev_reg <= 1'b1;
        else if (sample)
            pin_prev_reg <= pin_level;
    end

    assign count_en = run_control_bit && (timer_or_counter_select
        ? (sample && pin_prev_reg && !pin_level)
        : presc_tick);
    assign tick = count_en;

    assign count_next = {count_high_byte_reg, count_low_byte_reg} + 16'h0001;
    assign overflow = count_en && {count_high_byte_reg, count_low_byte_reg} == `TCS_COUNT_MAX;

    // AXI4-Lite write path: address and data taken in either order
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wr_ctrl = do_write && aw_addr_reg == `TCS_CTRL_OFFS && w_strb_reg[0];
    assign wr_count = do_write && aw_addr_reg == `TCS_COUNT_OFFS;

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_bresp = 2'b00;

    always_ff @(posedge mclk)
    begin
        if (rst)
            primary_control_register_reg <= 8'h00;
        else
        begin
            if (wr_ctrl)
                primary_control_register_reg <= w_data_reg[7:0];
            // Hardware set wins over a software clear in the same cycle
            if (overflow && !serial_clk_sel)
                primary_control_register_reg[`TCS_CT_OVF] <= 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            mode_control_register_reg <= {`TCS_PSC_RESET, 12'h000};
        else if (do_write && aw_addr_reg == `TCS_MODE_OFFS)
        begin
            if (w_strb_reg[0])
                mode_control_register_reg[1:0] <= w_data_reg[1:0];
            if (w_strb_reg[1])
                mode_control_register_reg[15:8] <= {w_data_reg[15:12], 2'b00, w_data_reg[9:8]};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            reload_capture_high_reg <= 8'h00;
            reload_capture_low_reg <= 8'h00;
        end
        else if (do_write && aw_addr_reg == `TCS_RELOAD_OFFS)
        begin
            if (w_strb_reg[0])
                reload_capture_low_reg <= w_data_reg[7:0];
            if (w_strb_reg[1])
                reload_capture_high_reg <= w_data_reg[15:8];
        end
    end

    // Counter: software write beats a tick in the same cycle
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            count_low_byte_reg <= 8'h00;
            count_high_byte_reg <= 8'h00;
        end
        else if (wr_count)
        begin
            if (w_strb_reg[0])
                count_low_byte_reg <= w_data_reg[7:0];
            if (w_strb_reg[1])
                count_high_byte_reg <= w_data_reg[15:8];
        end
        else if (count_en)
        begin
            // Bottom value for reload datapath is the reload pair; here wrap to minimum
            count_low_byte_reg <= count_next[7:0];
            count_high_byte_reg <= count_next[15:8];
        end
    end

    // AXI4-Lite read path; unmapped reads return zero with OKAY
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `TCS_CTRL_OFFS: s_axi_rdata <= {24'h00_0000, primary_control_register_reg};
                `TCS_MODE_OFFS: s_axi_rdata <= {16'h0000, mode_control_register_reg};
                `TCS_COUNT_OFFS: s_axi_rdata <= {16'h0000, count_high_byte_reg,
                    count_low_byte_reg};
                `TCS_RELOAD_OFFS: s_axi_rdata <= {16'h0000, reload_capture_high_reg,
                    reload_capture_low_reg};
                `TCS_STATUS_OFFS: s_axi_rdata <= {28'h000_0000, 1'b0, mode_next};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_rresp = 2'b00;

    logic [15:0] cnt_past;
    always_ff @(posedge mclk)
    begin
        if (rst)
            cnt_past <= 16'h0000;
        else
            cnt_past <= {count_high_byte_reg, count_low_byte_reg};
    end

    AST_INC_NEXT: assert property (@(posedge mclk) disable iff (rst)
        count_en && !wr_count |=> {count_high_byte_reg, count_low_byte_reg} == cnt_past + 16'h0001)
        else $error("count did not advance after enable");
    AST_HOLD_STOP: assert property (@(posedge mclk) disable iff (rst)
        !run_control_bit && !wr_count |=> {count_high_byte_reg, count_low_byte_reg} == cnt_past)
        else $error("count moved while stopped");
    AST_OVF_SET: assert property (@(posedge mclk) disable iff (rst)
        overflow && !serial_clk_sel |=> primary_control_register_reg[`TCS_CT_OVF])
        else $error("overflow flag not set");
    AST_OVF_SERIAL: assert property (@(posedge mclk) disable iff (rst)
        serial_clk_sel && !wr_ctrl && !primary_control_register_reg[`TCS_CT_OVF]
        |=> !primary_control_register_reg[`TCS_CT_OVF] || $past(wr_ctrl))
        else $error("overflow flag set in serial clock mode");
    AST_WRAP: assert property (@(posedge mclk) disable iff (rst)
        overflow && !wr_count |=> {count_high_byte_reg, count_low_byte_reg} == `TCS_COUNT_MIN)
        else $error("counter did not wrap to minimum");
    AST_FAST_FULL: assert property (@(posedge mclk) disable iff (rst)
        fast_mode && !rate_select_bit && run_control_bit && !timer_or_counter_select
        |-> count_en)
        else $error("fast mode without rate select must count every clock");
    AST_BYPASS: assert property (@(posedge mclk) disable iff (rst)
        (mode_next == TCS_FREQ || mode_next == TCS_BAUD) && !timer_or_counter_select |-> count_en)
        else $error("generator modes must bypass prescaler");
    AST_DEFAULT_SIX: assert property (@(posedge mclk) disable iff (rst)
        presc_tick && !presc_bypass && !presc_double && shared_prescale_value == 4'h5
        && $stable(shared_prescale_value)
        |=> (!presc_tick || presc_bypass || shared_prescale_value != 4'h5) [*5])
        else $error("default prescale must tick every six clocks");
    AST_COUNTER_EDGE: assert property (@(posedge mclk) disable iff (rst)
        timer_or_counter_select && count_en |-> pin_prev_reg && !pin_level)
        else $error("event count without falling edge");
    AST_OFF_MODE: assert property (@(posedge mclk) disable iff (rst)
        !run_control_bit |-> mode_next == TCS_OFF && !count_en)
        else $error("run bit clear must mean off");
    AST_PRESC_GAP: assert property (@(posedge mclk) disable iff (rst)
        presc_tick && !presc_bypass && shared_prescale_value != 4'h0
        |=> !presc_tick || presc_bypass)
        else $error("prescaled ticks back to back");
    AST_COMPAT_DOUBLE: assert property (@(posedge mclk) disable iff (rst)
        presc_tick && presc_double && !presc_bypass && shared_prescale_value == 4'h5
        |=> (!presc_tick || presc_bypass || !presc_double || shared_prescale_value != 4'h5) [*8])
        else $error("doubled prescale ticked early");
    AST_FAST_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
        fast_mode && timer_or_counter_select && run_control_bit && pin_prev_reg && !pin_level
        |-> count_en)
        else $error("fast mode missed a falling edge");
    AST_COMPAT_SAMPLE: assert property (@(posedge mclk) disable iff (rst)
        !fast_mode && timer_or_counter_select && count_en |-> presc_tick)
        else $error("event counted off the prescaler pace");
    AST_CARRY: assert property (@(posedge mclk) disable iff (rst)
        count_en && !wr_count && count_low_byte_reg == 8'hFF
        |=> count_high_byte_reg == $past(count_high_byte_reg) + 8'h01)
        else $error("no carry into high byte");
    AST_FLAG_HOLD: assert property (@(posedge mclk) disable iff (rst)
        primary_control_register_reg[`TCS_CT_OVF] && !wr_ctrl
        |=> primary_control_register_reg[`TCS_CT_OVF])
        else $error("overflow flag lost without software clear");
    AST_MODE_FREQ: assert property (@(posedge mclk) disable iff (rst)
        run_control_bit && mode_control_register_reg[`TCS_MD_TOGGLE] |-> mode_next == TCS_FREQ)
        else $error("toggle enable must mean frequency generator");
    AST_MODE_BAUD: assert property (@(posedge mclk) disable iff (rst)
        run_control_bit && !mode_control_register_reg[`TCS_MD_TOGGLE] && serial_clk_sel
        |-> mode_next == TCS_BAUD)
        else $error("serial clock select must mean baud generator");
endmodule
`default_nettype wire

/* tcs_event_src.sv */
// Behavioural external event source that drives the count pin
`default_nettype none
module tcs_event_src
(
    input wire logic mclk,
    input wire logic start,
    input wire logic [7:0] pulses,
    input wire logic [7:0] hold,
    output var logic pin,
    output var logic busy
);
    timeunit 1ns;
    timeprecision 100ps;
    // Rests high between bursts so only driven low phases are events
    initial
    begin
        pin = 1'b1;
        busy = 1'b0;
        forever
        begin
            @(posedge mclk);
            if (start === 1'b1)
            begin
                busy <= 1'b1;
                repeat (pulses)
                begin
                    pin <= 1'b0;
                    repeat (hold) @(posedge mclk);
                    pin <= 1'b1;
                    repeat (hold) @(posedge mclk);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* test_tcs_timer2.sv */
// Self-checking bench for the timer front end
`default_nettype none
`include "tcs_defines.svh"
module test_tcs_timer2 import tcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] RUN = 32'h0000_0004;
    localparam logic [31:0] TX = 32'h0000_0010;
    localparam logic [31:0] RX = 32'h0000_0020;
    localparam logic [31:0] CAP = 32'h0000_0001;
    localparam logic [31:0] CSEL = 32'h0000_0002;
    localparam logic [31:0] OVF = 32'h0000_0080;
    localparam logic [31:0] DOWN = 32'h0000_0001;
    localparam logic [31:0] TOG = 32'h0000_0002;
    localparam logic [31:0] RATE = 32'h0000_0100;
    localparam logic [31:0] FAST = 32'h0000_0200;
    localparam logic [31:0] PSC5 = 32'h0000_5000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ev_pin, ev_busy;
    logic ev_start = 1'b0;
    logic [7:0] ev_pulses = 8'h00, ev_hold = 8'h01;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd, ex;
    logic [2:0] mode;
    logic tick;
    int error_cnt = 0, samples_checked = 0, tick_seen = 0, t0, c;
    logic [31:0] tct [7] = '{32'h0000_0000, RUN | TX | CAP, RUN | RX | CAP, RUN | TX,
        RUN | CAP, RUN, RUN};
    logic [31:0] tmd [7] = '{PSC5 | TOG, PSC5 | TOG, PSC5, PSC5, PSC5 | DOWN, PSC5 | DOWN, PSC5};
    tcs_mode_t tex [7] = '{TCS_OFF, TCS_FREQ, TCS_BAUD, TCS_BAUD, TCS_CAPTURE, TCS_UPDOWN,
        TCS_RELOAD};
    logic [31:0] rc [7] = '{RUN, RUN, RUN, RUN, RUN, RUN | TX, RUN};
    logic [31:0] rm [7] = '{PSC5, PSC5 | RATE, PSC5 | FAST, 32'h0000_F300, 32'h0000_0300,
        PSC5 | RATE, PSC5 | TOG | RATE};
    logic [31:0] rp [7] = '{32'h0000_0006, 32'h0000_000C, 32'h0000_0001, 32'h0000_0010,
        32'h0000_0001, 32'h0000_0001, 32'h0000_0001};

    tcs_timer2 i_dut (.mclk(mclk), .rst(rst), .event_count_pin(ev_pin),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mode(mode), .tick(tick));
    tcs_event_src i_src (.mclk(mclk), .start(ev_start), .pulses(ev_pulses), .hold(ev_hold),
        .pin(ev_pin), .busy(ev_busy));

    always #12.5 mclk = ~mclk;
    // Sampled mid-cycle so the count never races the edge that consumes tick
    always @(negedge mclk) if (tick === 1'b1) tick_seen <= tick_seen + 1;

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic awp, wp, awh, wh;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        awp = 1'b1;
        wp = 1'b1;
        while (awp || wp)
        begin
            @(negedge mclk);
            awh = awp && s_axi_awready === 1'b1;
            wh = wp && s_axi_wready === 1'b1;
            @(posedge mclk);
            if (awh) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            awp = awp && !awh;
            wp = wp && !wh;
        end
        do @(negedge mclk); while (s_axi_bvalid !== 1'b1);
        check("bresp", 32'h0000_0000, {30'h0, s_axi_bresp});
        @(posedge mclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge mclk); while (s_axi_arready !== 1'b1);
        @(posedge mclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge mclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        @(posedge mclk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string nm);
        axi_read(a, rd);
        check(nm, exp, rd);
    endtask
    // The first tick after a setting change is skipped: only steady spacing is judged
    task automatic period(input logic [31:0] exp);
        c = 0;
        do @(negedge mclk); while (tick !== 1'b1);
        do
        begin
            @(negedge mclk);
            c++;
        end
        while (tick !== 1'b1);
        check("tick_period", exp, c);
    endtask
    task automatic send(input logic [7:0] n, input logic [7:0] h);
        @(posedge mclk);
        ev_pulses <= n;
        ev_hold <= h;
        ev_start <= 1'b1;
        @(posedge mclk);
        ev_start <= 1'b0;
        do @(negedge mclk); while (ev_busy !== 1'b0);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        final_report();
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd_check(`TCS_CTRL_OFFS, 32'h0000_0000, "ctrl_reset");
        rd_check(`TCS_MODE_OFFS, PSC5, "mode_reset");
        rd_check(`TCS_COUNT_OFFS, 32'h0000_0000, "count_reset");
        rd_check(`TCS_STATUS_OFFS, 32'h0000_0000, "status_reset");
        check("tick_stopped", 32'h0000_0000, {31'h0, tick});
        axi_write(`TCS_RELOAD_OFFS, 32'h0000_1234);
        rd_check(`TCS_RELOAD_OFFS, 32'h0000_1234, "bottom_pair");
        axi_write(8'h14, 32'h0000_00FF);
        rd_check(8'h14, 32'h0000_0000, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 7; i++)
        begin
            axi_write(`TCS_MODE_OFFS, tmd[i]);
            axi_write(`TCS_CTRL_OFFS, tct[i]);
            rd_check(`TCS_STATUS_OFFS, 32'(tex[i]), "status_mode");
            check("mode_port", 32'(tex[i]), {29'h0, mode});
        end
        axi_write(`TCS_STATUS_OFFS, 32'h0000_0007);
        rd_check(`TCS_STATUS_OFFS, 32'(TCS_RELOAD), "status_readonly");
        $display("test mode decode done");
        for (int i = 0; i < 7; i++)
        begin
            axi_write(`TCS_MODE_OFFS, rm[i]);
            axi_write(`TCS_CTRL_OFFS, rc[i]);
            period(rp[i]);
        end
        axi_write(`TCS_MODE_OFFS, 32'h0000_3300);
        period(32'h0000_0004);
        axi_write(`TCS_MODE_OFFS, 32'h0000_F300);
        c = 0;
        do @(negedge mclk); while (tick !== 1'b1 && ++c < 100);
        check("first_tick_late", 32'h0000_0001, 32'(c >= 12));
        // A shorter division is where a stale divider count would tick early
        axi_write(`TCS_MODE_OFFS, 32'h0000_3300);
        c = 0;
        do @(negedge mclk); while (tick !== 1'b1 && ++c < 100);
        check("first_tick_after_cut", 32'h0000_0001, 32'(c >= 3));
        $display("test prescaler done");
        axi_write(`TCS_CTRL_OFFS, 32'h0000_0000);
        axi_write(`TCS_MODE_OFFS, PSC5 | FAST);
        axi_write(`TCS_COUNT_OFFS, 32'h0000_00FD);
        t0 = tick_seen;
        axi_write(`TCS_CTRL_OFFS, RUN);
        axi_write(`TCS_CTRL_OFFS, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        ex = 32'h0000_00FD + 32'(tick_seen - t0);
        check("carry_reached", 32'h0000_0001, 32'(tick_seen - t0 >= 3));
        rd_check(`TCS_COUNT_OFFS, ex, "count_track");
        t0 = tick_seen;
        repeat (20) @(posedge mclk);
        check("ticks_while_stopped", t0, tick_seen);
        rd_check(`TCS_COUNT_OFFS, ex, "count_held");
        $display("test counting done");
        axi_write(`TCS_COUNT_OFFS, 32'h0000_0000);
        axi_write(`TCS_CTRL_OFFS, RUN | CSEL);
        t0 = tick_seen;
        // The pin filter needs two equal samples, so each level is held two clocks
        send(8'h05, 8'h02);
        repeat (8) @(posedge mclk);
        check("fast_ticks", 32'h0000_0005, tick_seen - t0);
        rd_check(`TCS_COUNT_OFFS, 32'h0000_0005, "fast_events");
        axi_write(`TCS_CTRL_OFFS, 32'h0000_0000);
        axi_write(`TCS_MODE_OFFS, PSC5);
        axi_write(`TCS_COUNT_OFFS, 32'h0000_0000);
        axi_write(`TCS_CTRL_OFFS, RUN | CSEL);
        send(8'h03, 8'h06);
        repeat (20) @(posedge mclk);
        rd_check(`TCS_COUNT_OFFS, 32'h0000_0003, "compat_events");
        $display("test event counting done");
        axi_write(`TCS_CTRL_OFFS, 32'h0000_0000);
        axi_write(`TCS_MODE_OFFS, PSC5 | FAST);
        axi_write(`TCS_COUNT_OFFS, 32'h0000_FFFE);
        axi_write(`TCS_CTRL_OFFS, RUN);
        rd_check(`TCS_CTRL_OFFS, RUN | OVF, "flag_set");
        axi_write(`TCS_CTRL_OFFS, 32'h0000_0000);
        rd_check(`TCS_CTRL_OFFS, 32'h0000_0000, "flag_clear");
        for (int i = 0; i < 2; i++)
        begin
            ex = i == 0 ? RUN | TX : RUN | RX;
            axi_write(`TCS_COUNT_OFFS, 32'h0000_FFFE);
            axi_write(`TCS_CTRL_OFFS, ex);
            repeat (6) @(posedge mclk);
            rd_check(`TCS_CTRL_OFFS, ex, "flag_blocked");
            axi_write(`TCS_CTRL_OFFS, 32'h0000_0000);
        end
        $display("test overflow flag done");
        final_report();
    end
endmodule
`default_nettype wire
